// >>> verilog/pum_port_mgmt.sv
// link management for the upstream x1 port of a bridge
// assumes clk at 100 MHz, pins synchronised here, message codes on 8 bits
// Behaviour
// - strap high selects 125 MHz single-ended reference, else 100 MHz differential.
// - beacon generation may only start while control bit 10 is set.
// - in L2 with beacon enabled, a secondary PME request starts beacon.
// - beacon continues until reset is deasserted, then stops.
// - wake pulled low to request power and clocks, released otherwise.
// - upstream drives reset; reset-class state returns to defaults meanwhile.
// - advertise 8 PH, 128 PD, 4 NPH, 4 NPD credits after init.
// - completion header and data credits advertised as zero, infinite.
// - listed interrupt, PM and error messages are transmitted upstream.
// - ASPM Nak, PME turn-off and slot power limit are processed.
// - unlock, hot-plug, switching, vendor type 1 are silently dropped.
// - vendor type 0 is answered as an unsupported request.
`timescale 1ns/1ps
`default_nettype none
`include "pum_params.svh"
module pum_port_mgmt (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        singleEndedClkSelect,
  input  wire logic        perstPin_n,
  input  wire logic        pmeReqPin_n,
  input  wire logic [15:0] genCtrl,
  input  wire logic        linkInL2,
  input  wire logic        linkUp,
  input  wire logic        txMsgReq,
  input  wire logic [7:0]  txMsgCode,
  output logic             txMsgAck,
  output logic             txMsgValid,
  output logic [7:0]       txMsgOut,
  input  wire logic        rxMsgValid,
  input  wire logic [7:0]  rxMsgCode,
  output logic             rxProcess,
  output logic             rxUnsupported,
  output logic             rxDropped,
  output logic             turnOffSeen,
  output logic             asNakSeen,
  output logic             slotPowerSeen,
  output logic             useSingleEndedRef,
  output logic             beaconActive,
  output logic             wakeOut,
  output logic             wakeOe,
  output logic             perstResetActive,
  output logic [7:0]       creditPh,
  output logic [11:0]      creditPd,
  output logic [7:0]       creditNph,
  output logic [11:0]      creditNpd,
  output logic [7:0]       creditCplh,
  output logic [11:0]      creditCpld,
  output logic             creditsValid
);
  logic [2:0] pinSync;
  logic       strapSync;
  logic       perstSync_n;
  logic       pmeSync_n;

  // the strap is a pin too, so it goes through the same flops
  pum_sync2 #(.WIDTH(3)) uSync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn ({singleEndedClkSelect, perstPin_n, pmeReqPin_n}),
    .syncOut (pinSync)
  );
  assign strapSync   = pinSync[2];
  assign perstSync_n = pinSync[1];
  assign pmeSync_n   = pinSync[0];

  function automatic logic isTxMsg(input logic [7:0] c);
    isTxMsg = (c[7:2] == 6'(`PUM_MSG_ASSERT_INTA >> 2))
           || (c[7:2] == 6'(`PUM_MSG_DEASSERT_INTA >> 2))
           || (c == `PUM_MSG_PM_PME) || (c == `PUM_MSG_PME_TO_ACK)
           || (c == `PUM_MSG_ERR_COR) || (c == `PUM_MSG_ERR_NONFATAL)
           || (c == `PUM_MSG_ERR_FATAL);
  endfunction

  function automatic pum_pkg::pum_rx_action_t rxClass(input logic [7:0] c);
    if (c == `PUM_MSG_PM_ASNAK || c == `PUM_MSG_PME_TURNOFF
        || c == `PUM_MSG_SLOT_PWR)
      rxClass = pum_pkg::PUM_RX_PROCESS;
    else if (c == `PUM_MSG_VENDOR0)
      rxClass = pum_pkg::PUM_RX_UR;
    else
      rxClass = pum_pkg::PUM_RX_DROP;
  endfunction

  // strap frozen once the synchroniser has filled after reset release
  logic [1:0]              strapAge_q;
  logic [1:0]              strapAge_d;
  logic                    strapSel_q;
  logic                    strapSel_d;
  pum_pkg::pum_bcn_state_t bcn_q;
  pum_pkg::pum_bcn_state_t bcn_d;
  logic                    wake_q;
  logic                    wake_d;
  logic credValid_q, credValid_d;
  logic [7:0] txOut_q, txOut_d;
  logic txValid_q, txValid_d;
  logic rxProc_q, rxProc_d, rxUr_q, rxUr_d, rxDrop_q, rxDrop_d;
  logic turnOff_q, turnOff_d, asNak_q, asNak_d, slotPwr_q, slotPwr_d;
  logic beaconEnable;
  pum_pkg::pum_rx_action_t act;

  assign beaconEnable = genCtrl[`PUM_BEACON_EN_BIT];

  // power group: beacon must live through PERST, so no PERST clear here
  always_comb
  begin
    strapAge_d = strapAge_q;
    strapSel_d = strapSel_q;
    if (strapAge_q != `PUM_STRAP_SETTLE)
    begin
      strapAge_d = strapAge_q + 2'h1;
      strapSel_d = strapSync;
    end
    bcn_d  = bcn_q;
    wake_d = wake_q;
    case (bcn_q)
      pum_pkg::PUM_BCN_IDLE:
      begin
        if (linkInL2 && beaconEnable && !pmeSync_n)
        begin
          bcn_d  = pum_pkg::PUM_BCN_SEND;
          wake_d = 1'b1;
        end
      end
      pum_pkg::PUM_BCN_SEND:
      begin
        if (perstSync_n)
        begin
          bcn_d  = pum_pkg::PUM_BCN_IDLE;
          wake_d = 1'b0;
        end
      end
      default: bcn_d = pum_pkg::PUM_BCN_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strapAge_q <= 2'h0;
      strapSel_q <= 1'b0;
      bcn_q      <= pum_pkg::PUM_BCN_IDLE;
      wake_q     <= 1'b0;
    end
    else
    begin
      strapAge_q <= strapAge_d;
      strapSel_q <= strapSel_d;
      bcn_q      <= bcn_d;
      wake_q     <= wake_d;
    end
  end

  // message group: every pulse and the credit flag are PERST-reset
  always_comb
  begin
    credValid_d = linkUp && perstSync_n;
    txValid_d = txMsgReq && isTxMsg(txMsgCode) && perstSync_n;
    txOut_d   = txValid_d ? txMsgCode : txOut_q;
    act       = rxClass(rxMsgCode);
    rxProc_d  = rxMsgValid && act == pum_pkg::PUM_RX_PROCESS;
    rxUr_d    = rxMsgValid && act == pum_pkg::PUM_RX_UR;
    rxDrop_d  = rxMsgValid && act == pum_pkg::PUM_RX_DROP;
    turnOff_d = rxProc_d && rxMsgCode == `PUM_MSG_PME_TURNOFF;
    asNak_d   = rxProc_d && rxMsgCode == `PUM_MSG_PM_ASNAK;
    slotPwr_d = rxProc_d && rxMsgCode == `PUM_MSG_SLOT_PWR;
    if (!perstSync_n)
    begin
      credValid_d = 1'b0;
      txValid_d   = 1'b0;
      rxProc_d    = 1'b0;
      rxUr_d      = 1'b0;
      rxDrop_d    = 1'b0;
      turnOff_d   = 1'b0;
      asNak_d     = 1'b0;
      slotPwr_d   = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      credValid_q <= 1'b0;
      txValid_q   <= 1'b0;
      txOut_q     <= 8'h00;
      rxProc_q    <= 1'b0;
      rxUr_q      <= 1'b0;
      rxDrop_q    <= 1'b0;
      turnOff_q   <= 1'b0;
      asNak_q     <= 1'b0;
      slotPwr_q   <= 1'b0;
    end
    else
    begin
      credValid_q <= credValid_d;
      txValid_q   <= txValid_d;
      txOut_q     <= txOut_d;
      rxProc_q    <= rxProc_d;
      rxUr_q      <= rxUr_d;
      rxDrop_q    <= rxDrop_d;
      turnOff_q   <= turnOff_d;
      asNak_q     <= asNak_d;
      slotPwr_q   <= slotPwr_d;
    end
  end

  // requests outside the transmit list are accepted but never sent
  assign txMsgAck          = txMsgReq;
  assign txMsgValid        = txValid_q;
  assign txMsgOut          = txOut_q;
  assign rxProcess         = rxProc_q;
  assign rxUnsupported     = rxUr_q;
  assign rxDropped         = rxDrop_q;
  assign turnOffSeen       = turnOff_q;
  assign asNakSeen         = asNak_q;
  assign slotPowerSeen     = slotPwr_q;
  assign useSingleEndedRef = strapSel_q;
  assign beaconActive      = bcn_q == pum_pkg::PUM_BCN_SEND;
  // open drain: output always low, enable asserts the pull
  assign wakeOut           = 1'b0;
  assign wakeOe            = wake_q;
  assign perstResetActive  = !perstSync_n;
  assign creditPh   = credValid_q ? `PUM_CREDIT_PH   : 8'h00;
  assign creditPd   = credValid_q ? `PUM_CREDIT_PD   : 12'h000;
  assign creditNph  = credValid_q ? `PUM_CREDIT_NPH  : 8'h00;
  assign creditNpd  = credValid_q ? `PUM_CREDIT_NPD  : 12'h000;
  assign creditCplh = `PUM_CREDIT_CPLH;
  assign creditCpld = `PUM_CREDIT_CPLD;
  assign creditsValid = credValid_q;
endmodule // pum_port_mgmt
`default_nettype wire

// >>> verilog/pum_params.svh
// constants for the upstream port management block
// assumes inclusion by bare name from the design files
`ifndef PUM_PARAMS_SVH
`define PUM_PARAMS_SVH
`define PUM_BEACON_EN_BIT   4'hA
`define PUM_GEN_CTRL_OFFSET 8'hD4
`define PUM_STRAP_SETTLE    2'h3
`define PUM_CREDIT_PH       8'h08
`define PUM_CREDIT_PD       12'h080
`define PUM_CREDIT_NPH      8'h04
`define PUM_CREDIT_NPD      12'h004
`define PUM_CREDIT_CPLH     8'h00
`define PUM_CREDIT_CPLD     12'h000
`define PUM_MSG_ASSERT_INTA 8'h20
`define PUM_MSG_DEASSERT_INTA 8'h24
`define PUM_MSG_PM_ASNAK    8'h14
`define PUM_MSG_PM_PME      8'h18
`define PUM_MSG_PME_TURNOFF 8'h19
`define PUM_MSG_PME_TO_ACK  8'h1B
`define PUM_MSG_ERR_COR     8'h30
`define PUM_MSG_ERR_NONFATAL 8'h31
`define PUM_MSG_ERR_FATAL   8'h33
`define PUM_MSG_UNLOCK      8'h00
`define PUM_MSG_SLOT_PWR    8'h50
`define PUM_MSG_VENDOR0     8'h7E
`define PUM_MSG_VENDOR1     8'h7F
`define PUM_MSG_HP_BASE     8'h40
`define PUM_MSG_HP_MASK     8'hF0
`define PUM_MSG_AS_BASE     8'h60
`define PUM_MSG_AS_MASK     8'hF0
`endif

// >>> verilog/pum_pkg.sv
// types for the upstream port management block
// assumes nothing of its surroundings
package pum_pkg;
  typedef enum logic [1:0] {
    PUM_RX_DROP    = 2'h0,
    PUM_RX_PROCESS = 2'h1,
    PUM_RX_UR      = 2'h2
  } pum_rx_action_t;
  typedef enum logic [1:0] {
    PUM_BCN_IDLE = 2'h0,
    PUM_BCN_SEND = 2'h1
  } pum_bcn_state_t;
endpackage

// >>> verilog/pum_sync2.sv
// two-flop synchroniser for a level from outside the clock domain
// assumes the input changes slowly relative to clk
`timescale 1ns/1ps
`default_nettype none
module pum_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;
endmodule // pum_sync2
`default_nettype wire

// >>> tb/pum_port_mgmt_assertions.sv
// port checks for the upstream port management block
// assumes a bind onto pum_port_mgmt, one clock domain
`timescale 1ns/1ps
`default_nettype none
module pum_port_mgmt_assertions (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        perstResetActive,
  input wire logic        linkInL2,
  input wire logic        beaconActive,
  input wire logic        wakeOe,
  input wire logic        wakeOut,
  input wire logic        creditsValid,
  input wire logic        txMsgReq,
  input wire logic        txMsgValid,
  input wire logic        rxMsgValid,
  input wire logic        rxProcess,
  input wire logic        rxUnsupported,
  input wire logic        rxDropped,
  input wire logic [15:0] genCtrl,
  input wire logic [7:0]  txMsgCode,
  input wire logic [7:0]  txMsgOut,
  input wire logic [7:0]  rxMsgCode,
  input wire logic [7:0]  creditPh,
  input wire logic [11:0] creditPd
);
  logic txTake;
  logic rxTake;
  assign txTake = txMsgReq && !perstResetActive && (txMsgCode inside
    {[8'h20:8'h27], 8'h18, 8'h1B, 8'h30, 8'h31, 8'h33});
  assign rxTake = rxMsgValid && !perstResetActive;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_tx_sent: assert property (txTake |=> txMsgValid
    && txMsgOut == $past(txMsgCode)) else $error("tx lost");
  a_tx_refused: assert property (txMsgValid |-> $past(txTake))
    else $error("tx not allowed");
  a_rx_ur: assert property (rxTake && rxMsgCode == 8'h7E
    |=> rxUnsupported) else $error("no UR");
  a_rx_process: assert property (rxTake && rxMsgCode inside
    {8'h14, 8'h19, 8'h50} |=> rxProcess) else $error("not processed");
  a_rx_drop: assert property (rxTake && rxMsgCode inside
    {8'h00, 8'h7F, [8'h40:8'h4F], [8'h60:8'h6F]} |=> rxDropped)
    else $error("not dropped");
  a_wake_release: assert property (wakeOe && !perstResetActive
    |=> !wakeOe) else $error("wake held");
  a_credits_fixed: assert property (creditsValid |->
    creditPh == 8'h08 && creditPd == 12'h080) else $error("bad credit");
  a_beacon_gate: assert property (!genCtrl[10] && !beaconActive
    |=> !beaconActive) else $error("beacon disabled");
  a_beacon_stop: assert property (beaconActive && !perstResetActive
    && !linkInL2 |=> !beaconActive) else $error("beacon stuck");
  a_wake_beacon: assert property
    (wakeOe == beaconActive && !wakeOut) else $error("wake mismatch");
  cover property (txMsgValid);
  cover property (rxUnsupported);
  cover property (beaconActive);
endmodule // pum_port_mgmt_assertions
bind pum_port_mgmt pum_port_mgmt_assertions chk (.*);
`default_nettype wire

// >>> tb/pum_upstream_model.sv
// upstream port model: drives reset and link state
// assumes wakeOe high asks for main power back
`timescale 1ns/1ps
`default_nettype none
module pum_upstream_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sleepReq,
  input  wire logic slow,
  input  wire logic wakeOe,
  output logic      perstPin_n,
  output logic      linkInL2,
  output logic      linkUp
);
  logic [4:0] cnt;
  // in L2 power returns only on a wake request
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      {perstPin_n, linkInL2, linkUp, cnt} <= 8'h00;
    else if (sleepReq)
      {perstPin_n, linkInL2, linkUp, cnt} <= 8'h40;
    else if (!perstPin_n && (!linkInL2 || wakeOe))
      {perstPin_n, linkInL2, cnt} <= (cnt == (slow ? 5'h14 : 5'h03)) ?
        7'h40 : {1'b0, linkInL2, cnt + 5'h01};
    else
      linkUp <= perstPin_n;
endmodule // pum_upstream_model
`default_nettype wire

// >>> tb/pum_port_mgmt_tb.sv
// self-checking bench for the upstream port management block
// assumes the host model answers reset and wake
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end
module pum_port_mgmt_tb;
  logic clk, rst_n, singleEndedClkSelect, perstPin_n, pmeReqPin_n;
  logic linkInL2, linkUp, txMsgReq, txMsgAck, txMsgValid, rxMsgValid;
  logic rxProcess, rxUnsupported, rxDropped, turnOffSeen, asNakSeen;
  logic slotPowerSeen, useSingleEndedRef, beaconActive, wakeOut, wakeOe;
  logic perstResetActive, creditsValid, sleepReq, slow;
  logic [15:0] genCtrl;
  logic [7:0] txMsgCode, txMsgOut, rxMsgCode, creditPh, creditNph;
  logic [7:0] creditCplh, tbl [17];
  logic [11:0] creditPd, creditNpd, creditCpld;
  logic [14:0] q [$], got, exp;
  int failures, numChecks;
  pum_port_mgmt DUT (.*);
  pum_upstream_model host (.*);
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [14:0] expOf(input logic t, input logic [7:0] c);
    if (t)
      return (c inside {[8'h20:8'h27], 8'h18, 8'h1B, 8'h30, 8'h31, 8'h33})
        ? {7'h40, c} : 15'h0;
    case (c)
      8'h7E: return 15'h1000;
      8'h14: return 15'h2200;
      8'h19: return 15'h2400;
      8'h50: return 15'h2100;
      default: return 15'h0800;
    endcase
  endfunction
  task automatic send(input logic t, input logic [7:0] c);
    tick(1);
    {txMsgReq, rxMsgValid, txMsgCode, rxMsgCode} = {t, !t, c, c};
    if (perstPin_n && expOf(t, c) != 15'h0) q.push_back(expOf(t, c));
    #1;
    `CHK(txMsgAck, t)
  endtask
  task automatic idle;
    tick(1);
    {txMsgReq, rxMsgValid} = 2'h0;
  endtask
  task automatic up;
    repeat (80) if (!linkUp) tick(1);
    tick(4);
    `CHK({linkUp, creditsValid, perstResetActive}, 3'h6)
    `CHK({creditPh, creditPd, creditNph, creditNpd}, 40'h08_080_04_004)
    `CHK({creditCplh, creditCpld}, 20'h0)
  endtask
  task automatic reset(input logic s);
    rst_n = 0;
    singleEndedClkSelect = s;
    tick(10);
    rst_n = 1;
    up;
    `CHK(useSingleEndedRef, s)
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(negedge clk)
    if ((txMsgValid | rxProcess | rxUnsupported | rxDropped) !== 1'b0)
    begin
      got = {txMsgValid, rxProcess, rxUnsupported, rxDropped, turnOffSeen,
        asNakSeen, slotPowerSeen, txMsgValid ? txMsgOut : 8'h00};
      exp = q.size() ? q.pop_front() : 15'h7FFF;
      `CHK(got, exp)
    end
  initial
  begin
    tick(5000);
    failures++;
    final_report;
  end
  initial
  begin
    {rst_n, sleepReq, slow, txMsgReq, rxMsgValid, singleEndedClkSelect} = '0;
    {txMsgCode, rxMsgCode, genCtrl, pmeReqPin_n} = 33'h1;
    tbl = '{8'h20, 8'h24, 8'h27, 8'h28, 8'h18, 8'h1B, 8'h30, 8'h31, 8'h33,
      8'h14, 8'h19, 8'h50, 8'h00, 8'h40, 8'h60, 8'h7E, 8'h7F};
    void'($urandom(32'h351B));
    reset(1'b1);
    foreach (tbl[i])
    begin
      send(1'b1, tbl[i]);
      send(1'b0, tbl[i]);
    end
    repeat (60) send(1'($urandom), 8'($urandom));
    idle;
    sleepReq = 1;
    tick(1);
    sleepReq = 0;
    tick(3);
    `CHK(perstResetActive, 1'b1)
    send(1'b1, 8'h30);
    send(1'b0, 8'h7E);
    idle;
    pmeReqPin_n = 0;
    tick(6);
    `CHK(beaconActive, 1'b0)
    slow = 1;
    genCtrl = 16'($urandom) | 16'h0400;
    tick(4);
    `CHK(beaconActive, 1'b1)
    pmeReqPin_n = 1;
    genCtrl[10] = 0;
    tick(5);
    `CHK({beaconActive, wakeOe, wakeOut}, 3'h6)
    up;
    `CHK({beaconActive, wakeOe}, 2'h0)
    reset(1'b0);
    repeat (20) send(1'($urandom), 8'($urandom));
    idle;
    pmeReqPin_n = 0;
    genCtrl[10] = 1;
    tick(4);
    `CHK(beaconActive, 1'b0)
    `CHK(q.size(), 0)
    final_report;
  end
endmodule // pum_port_mgmt_tb
`default_nettype wire
